//--- logic/tbcmd_decoder.sv
// Texel decoder for direct four-colour and split-pair compressed blocks.
// Overview of operation
// - 010 top bits direct; top one split.
// - Texel n selector at bits 2n+1:2n.
// - Direct: ignore bit 124, replicate 5-bit channels.
// - Direct: selector picks colour, alpha 0FFh.
// - Bit 127 set means split-pair mode.
// - Bits 126/125 green extra; 124 is flag.
// - Flag zero: colours 2,0 extra green XORed.
// - Flag zero: all colours 5-6-5 expanded.
// - Flag zero low half: thirds table c0,c1.
// - Flag zero high half: thirds table c2,c3.
// - Flag one: c0,c2 5-5-5; c1,c3 5-6-5.
// - Flag one low half: c0, midpoint, c1, clear.
// - Flag one high half: c2, midpoint, c3, clear.
// - Flag one selector 3 gives all zero.
`timescale 1ns/1ps
module tbcmd_decoder (
	// Clock and reset.
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	// Request from the sampling logic.
	input  wire logic         valid_i,
	input  wire logic [127:0] block_i,
	input  wire logic [4:0]   index_i,
	// Decoded texel.
	output logic              valid_o,
	output logic              unsupported_o,
	output logic      [31:0]  argb_o
);

	// ==========================================================================
	// Decode of the block fields
	tbcmd_pkg::tbcmd_state_t st;
	tbcmd_pkg::tbcmd_state_t next_st;
	tbcmd_pkg::tbcmd_kind_t  kind;
	logic                    flag;
	logic [1:0]              sel;
	logic [3:0]              gx;
	logic [3:0]              six;
	logic [7:0]              exp_r [4];
	logic [7:0]              exp_g [4];
	logic [7:0]              exp_b [4];
	logic [23:0]             pair_a;
	logic [23:0]             pair_b;
	logic [23:0]             blend;

	// Mode detection and texel selector fetch.
	always_comb begin
		flag = block_i[tbcmd_pkg::FLAG_BIT];
		// mode selection by the top bits.
		// top bit alone marks split-pair mode.
		if (block_i[tbcmd_pkg::MODE_MSB]) begin
			kind = tbcmd_pkg::KIND_SPLIT;
		end else if (block_i[tbcmd_pkg::MODE_MSB -: tbcmd_pkg::MODE_W] == tbcmd_pkg::MODE_DIRECT) begin
			kind = tbcmd_pkg::KIND_DIRECT;
		end else begin
			kind = tbcmd_pkg::KIND_UNSUPPORTED;
		end
		sel = block_i[{index_i, 1'b0} +: tbcmd_pkg::SEL_W];
	end

	// Extra green bits and which colours carry six green bits.
	always_comb begin
		// extra green bits of colours 3 and 1.
		gx[3] = block_i[tbcmd_pkg::G3_EXTRA_BIT];
		gx[1] = block_i[tbcmd_pkg::G1_EXTRA_BIT];
		// folded extra green bits of colours 2 and 0.
		gx[2] = block_i[tbcmd_pkg::G2_XOR_BIT] ^ block_i[tbcmd_pkg::G3_EXTRA_BIT];
		gx[0] = block_i[tbcmd_pkg::G0_XOR_BIT] ^ block_i[tbcmd_pkg::G1_EXTRA_BIT];
		// flag zero widens all four colours.
		// flag one widens only colours 1 and 3.
		if (kind != tbcmd_pkg::KIND_SPLIT) begin
			six = 4'h0;
		end else if (flag) begin
			six = 4'hA;
		end else begin
			six = 4'hF;
		end
	end

	// Channel expansion by replicating the upper bits.
	always_comb begin
		logic [4:0] r5;
		logic [4:0] g5;
		logic [4:0] b5;
		r5 = 5'h00;
		g5 = 5'h00;
		b5 = 5'h00;
		for (int k = 0; k < tbcmd_pkg::NUM_COLORS; k++) begin
			r5 = block_i[tbcmd_pkg::COLOR_BASE_LSB + k*tbcmd_pkg::COLOR_FIELD_W + tbcmd_pkg::RED_OFS +: tbcmd_pkg::CHAN_W];
			g5 = block_i[tbcmd_pkg::COLOR_BASE_LSB + k*tbcmd_pkg::COLOR_FIELD_W + tbcmd_pkg::GREEN_OFS +: tbcmd_pkg::CHAN_W];
			b5 = block_i[tbcmd_pkg::COLOR_BASE_LSB + k*tbcmd_pkg::COLOR_FIELD_W +: tbcmd_pkg::CHAN_W];
			// five-bit channels copy their top three bits below.
			exp_r[k] = {r5, r5[4:2]};
			exp_b[k] = {b5, b5[4:2]};
			// six-bit green repeats its top two bits below.
			exp_g[k] = six[k] ? {g5, gx[k], g5[4:3]} : {g5, g5[4:2]};
		end
	end

	// Base pair of the addressed half.
	always_comb begin
		// index top bit picks the colour pair.
		if (index_i[4]) begin
			pair_a = {exp_r[2], exp_g[2], exp_b[2]};
			pair_b = {exp_r[3], exp_g[3], exp_b[3]};
		end else begin
			pair_a = {exp_r[0], exp_g[0], exp_b[0]};
			pair_b = {exp_r[1], exp_g[1], exp_b[1]};
		end
	end

	// ==========================================================================
	// Table lookup, one blender per channel
	// thirds table on the lower half.
	// thirds table on the upper half.
	// midpoint table on the lower half.
	// midpoint table on the upper half.
	for (genvar ch = 0; ch < 3; ch++) begin : g_chan
		tbcmd_lerp #(
			.W (8)
		) u_lerp (
			.a_i      (pair_a[ch*8 +: 8]),
			.b_i      (pair_b[ch*8 +: 8]),
			.sel_i    (sel),
			.thirds_i (~flag),
			.y_o      (blend[ch*8 +: 8])
		);
	end

	// ==========================================================================
	// Result register
	always_comb begin
		next_st             = st;
		next_st.valid       = valid_i;
		next_st.unsupported = 1'b0;
		if (valid_i) begin
			case (kind)
				tbcmd_pkg::KIND_DIRECT: begin
					next_st.argb = {tbcmd_pkg::ALPHA_OPAQUE, exp_r[sel], exp_g[sel], exp_b[sel]};
				end
				tbcmd_pkg::KIND_SPLIT: begin
					if (flag && sel == tbcmd_pkg::SEL_CLEAR) begin
						next_st.argb = {tbcmd_pkg::ALPHA_CLEAR, 24'h000000};
					end else begin
						next_st.argb = {tbcmd_pkg::ALPHA_OPAQUE, blend};
					end
				end
				default: begin
					next_st.unsupported = 1'b1;
					next_st.argb        = tbcmd_pkg::ARGB_RESET;
				end
			endcase
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st <= '{valid: 1'b0, unsupported: 1'b0, argb: tbcmd_pkg::ARGB_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign valid_o       = st.valid;
	assign unsupported_o = st.unsupported;
	assign argb_o        = st.argb;

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_direct_in;
		valid_i && block_i[127:125] == 3'h2;
	endsequence
	sequence s_split_opaque_in;
		valid_i && block_i[127] && !block_i[124];
	endsequence
	sequence s_split_clear_in;
		valid_i && block_i[127] && block_i[124];
	endsequence

	direct_alpha_a: assert property (s_direct_in |=> valid_o && argb_o[31:24] == 8'hFF)
		else $error("Direct mode alpha not opaque.");
	direct_pick_a: assert property (s_direct_in ##0 (block_i[{index_i, 1'b0} +: 2] == 2'h0)
		|=> argb_o[23:16] == {$past(block_i[78:74]), $past(block_i[78:76])})
		else $error("Direct mode colour 0 red wrong.");
	split_seen_a: assert property (valid_i && block_i[127] |=> valid_o && !unsupported_o)
		else $error("Split-pair block not decoded.");
	other_mode_a: assert property (valid_i && !block_i[127] && block_i[126:125] != 2'h2
		|=> unsupported_o && argb_o == 32'h0)
		else $error("Unsupported mode not flagged.");
	opaque_alpha_a: assert property (s_split_opaque_in |=> argb_o[31:24] == 8'hFF)
		else $error("Opaque variant alpha wrong.");
	green_fold_a: assert property (s_split_opaque_in ##0 (!index_i[4] && block_i[{index_i, 1'b0} +: 2] == 2'h0)
		|=> argb_o[10] == ($past(block_i[1]) ^ $past(block_i[125])))
		else $error("Colour 0 extra green bit wrong.");
	upper_base_a: assert property (s_split_opaque_in ##0 (index_i[4] && block_i[{index_i, 1'b0} +: 2] == 2'h0)
		|=> argb_o[23:16] == {$past(block_i[108:104]), $past(block_i[108:106])})
		else $error("Upper half colour 2 red wrong.");
	third_blend_a: assert property (s_split_opaque_in ##0 (!index_i[4] && block_i[{index_i, 1'b0} +: 2] == 2'h1)
		|=> argb_o[7:0] == 8'((({2'h0, $past(block_i[68:64]), $past(block_i[68:66])} << 1)
		+ {2'h0, $past(block_i[83:79]), $past(block_i[83:81])} + 10'h001) / 10'h003))
		else $error("Lower half thirds blend wrong.");
	clear_entry_a: assert property (s_split_clear_in ##0 (block_i[{index_i, 1'b0} +: 2] == 2'h3)
		|=> argb_o == 32'h0)
		else $error("Transparent entry not zero.");
	mid_blend_a: assert property (s_split_clear_in ##0 (!index_i[4] && block_i[{index_i, 1'b0} +: 2] == 2'h1)
		|=> argb_o[23:16] == 8'(({1'b0, $past(block_i[78:74]), $past(block_i[78:76])}
		+ {1'b0, $past(block_i[93:89]), $past(block_i[93:91])}) >> 1) && argb_o[31:24] == 8'hFF)
		else $error("Lower half midpoint wrong.");
	plain_green_a: assert property (s_split_clear_in ##0 (!index_i[4] && block_i[{index_i, 1'b0} +: 2] == 2'h0)
		|=> argb_o[15:8] == {$past(block_i[73:69]), $past(block_i[73:71])})
		else $error("Colour 0 green not five-bit expanded.");
	idle_out_a: assert property (!valid_i |=> !valid_o ##1 (valid_o == $past(valid_i)))
		else $error("Output valid does not follow request.");

endmodule

//--- logic/tbcmd_pkg.sv
// Package with block field positions, constants and types for the texel block decoder.
package tbcmd_pkg;

	// ==========================================================================
	// Block field positions
	localparam int MODE_MSB        = 127;  // Top bit of the mode field.
	localparam int MODE_W          = 3;    // Width of the direct mode field.
	localparam int FLAG_BIT        = 124;  // Transparency variant flag in split-pair mode.
	localparam int G3_EXTRA_BIT    = 126;  // Extra green bit of colour 3.
	localparam int G1_EXTRA_BIT    = 125;  // Extra green bit of colour 1.
	localparam int G2_XOR_BIT      = 33;   // Folded into colour 2 extra green bit.
	localparam int G0_XOR_BIT      = 1;    // Folded into colour 0 extra green bit.
	localparam int COLOR_BASE_LSB  = 64;   // Lowest bit of colour 0 blue.
	localparam int COLOR_FIELD_W   = 15;   // Bits per packed colour.
	localparam int CHAN_W          = 5;    // Bits per packed channel.
	localparam int GREEN_OFS       = 5;    // Green offset inside a colour.
	localparam int RED_OFS         = 10;   // Red offset inside a colour.
	localparam int SEL_W           = 2;    // Texel selector width.
	localparam int NUM_COLORS      = 4;    // Colours held in a block.

	// ==========================================================================
	// Values
	localparam logic [2:0] MODE_DIRECT  = 3'h2;   // Mode code of the direct four-colour mode.
	localparam logic [7:0] ALPHA_OPAQUE = 8'hFF;  // Alpha of an opaque texel.
	localparam logic [7:0] ALPHA_CLEAR  = 8'h00;  // Alpha of the transparent entry.
	localparam logic [1:0] SEL_CLEAR    = 2'h3;   // Selector of the transparent entry.
	localparam logic [31:0] ARGB_RESET  = 32'h00000000;  // Output colour after reset.

	// ==========================================================================
	// Types
	typedef enum logic [1:0] {
		KIND_DIRECT,
		KIND_SPLIT,
		KIND_UNSUPPORTED
	} tbcmd_kind_t;

	typedef struct packed {
		logic        valid;
		logic        unsupported;
		logic [31:0] argb;
	} tbcmd_state_t;

endpackage

//--- logic/tbcmd_lerp.sv
// Per-channel colour table entry for one half of a split-pair block.
`timescale 1ns/1ps
module tbcmd_lerp #(
	parameter int W = 8
) (
	// Base colours of the half.
	input  wire logic [W-1:0] a_i,
	input  wire logic [W-1:0] b_i,
	// Texel selector and table variant.
	input  wire logic [1:0]   sel_i,
	input  wire logic         thirds_i,
	// Chosen channel value.
	output logic      [W-1:0] y_o
);

	logic [W+1:0] a_w;
	logic [W+1:0] b_w;
	logic [W+1:0] near_a;
	logic [W+1:0] near_b;
	logic [W+1:0] mid;

	// Unsigned blends with truncating division.
	// per-channel integer blends.
	always_comb begin
		a_w    = {2'h0, a_i};
		b_w    = {2'h0, b_i};
		near_a = ((a_w << 1) + b_w + (W+2)'(1)) / (W+2)'(3);
		near_b = (a_w + (b_w << 1) + (W+2)'(1)) / (W+2)'(3);
		mid    = (a_w + b_w) >> 1;
	end

	// Table lookup: thirds table for the opaque variant, midpoint table otherwise.
	always_comb begin
		case (sel_i)
			2'h0: y_o = a_i;
			2'h1: y_o = thirds_i ? near_a[W-1:0] : mid[W-1:0];
			2'h2: y_o = thirds_i ? near_b[W-1:0] : b_i;
			default: y_o = thirds_i ? b_i : '0;
		endcase
	end

endmodule

//--- tb/tbcmd_sampler_model.sv
// Request-side model of the texture sampling logic that feeds the decoder.
`timescale 1ns/1ps
module tbcmd_sampler_model (
	// Clock.
	input  wire logic         clk_sys_i,
	// Requests towards the decoder.
	output logic              valid_o,
	output logic      [127:0] block_o,
	output logic      [4:0]   index_o
);
	// ==========================================================================
	// Request driving
	// Lines start idle before the first request.
	initial begin
		valid_o = 1'h0;
		block_o = 128'h0;
		index_o = 5'h0;
	end

	// index beside block.
	// Drives one cycle; an idle cycle shows inverted data so a stale value never passes.
	task automatic drive(input logic v, input logic [127:0] blk, input logic [4:0] idx);
		@(posedge clk_sys_i);
		valid_o <= v;
		block_o <= v ? blk : ~block_o;
		index_o <= v ? idx : ~index_o;
	endtask
endmodule

//--- tb/tbcmd_decoder_bench.sv
// Self-checking bench for the texel block decoder.
`timescale 1ns/1ps
module tbcmd_decoder_bench;
	// One case: request beside the result it should give.
	typedef struct {
		logic [127:0] blk;
		logic [4:0]   idx;
		logic [31:0]  argb;
		logic         unsup;
	} tbcmd_row_t;

	logic             clk_sys_i;
	logic             sys_rst_i;
	wire logic        valid_i;
	wire logic [127:0] block_i;
	wire logic [4:0]  index_i;
	logic             valid_o;
	logic             unsupported_o;
	logic      [31:0] argb_o;
	logic     [127:0] blk;
	int               error_cnt;
	int               num_checks;
	tbcmd_row_t       rows[$];
	logic      [3:0]  nibs[10] = '{4'h4, 4'h5, 4'h8, 4'hE, 4'h9, 4'hF, 4'hC, 4'h0, 4'h2, 4'h6};
	logic      [59:0] cols[2] = '{60'hF0A5C39E17B24D6, 60'h0FFF8003FFE0001};
	logic      [63:0] sels[2] = '{64'hE4E4E4E4E4E4E4E4, 64'h1B1B1B1B1B1B1B1B};
	logic      [4:0]  ids[9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1F};

	// ==========================================================================
	// Design, request model and clock
	tbcmd_decoder DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .valid_i(valid_i), .block_i(block_i),
		.index_i(index_i), .valid_o(valid_o), .unsupported_o(unsupported_o), .argb_o(argb_o));
	tbcmd_sampler_model u_req (.clk_sys_i(clk_sys_i), .valid_o(valid_i), .block_o(block_i), .index_o(index_i));

	// Clock of 100 ns period.
	initial begin
		clk_sys_i = 1'h0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================================================
	// Reference decode
	// Picks one channel of a half table; truncating integer blends.
	function automatic logic [7:0] mix(input int a, input int c, input logic [1:0] s, input logic f);
		case (s)
			2'h0: return a[7:0];
			2'h1: return f ? 8'((a + c) / 2) : 8'((2 * a + c + 1) / 3);
			2'h2: return f ? c[7:0] : 8'((a + 2 * c + 1) / 3);
			default: return f ? 8'h00 : c[7:0];
		endcase
	endfunction

	// Works out the colour a texel should decode to.
	function automatic logic [31:0] expect_argb(input logic [127:0] b, input logic [4:0] ix);
		logic [7:0]  r[4];
		logic [7:0]  g[4];
		logic [7:0]  u[4];
		logic [3:0]  e;
		logic [14:0] f;
		logic [1:0]  s;
		int          h;
		s = b[2 * ix +: 2];
		e = {b[126], b[33] ^ b[126], b[125], b[1] ^ b[125]};
		for (int k = 0; k < 4; k++) begin
			f = b[64 + 15 * k +: 15];
			r[k] = {f[14:10], f[14:12]};
			u[k] = {f[4:0], f[4:2]};
			g[k] = (b[127] && (!b[124] || k[0])) ? {f[9:5], e[k], f[9:8]} : {f[9:5], f[9:7]};
		end
		if (b[127:125] == 3'h2) return {8'hFF, r[s], g[s], u[s]};
		if (!b[127] || (b[124] && s == 2'h3)) return 32'h0;
		h = ix[4] ? 2 : 0;
		return {8'hFF, mix(r[h], r[h + 1], s, b[124]), mix(g[h], g[h + 1], s, b[124]),
			mix(u[h], u[h + 1], s, b[124])};
	endfunction

	// ==========================================================================
	// Compare and closing tasks
	// Compares a one-bit result.
	task automatic chk1(input string nm, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask

	// Compares a colour result.
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Cuts a hang short well after the expected run length.
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		error_cnt++;
		test_done;
	end

	// ==========================================================================
	// Main sequence
	initial begin
		sys_rst_i = 1'h1;
		error_cnt = 0;
		num_checks = 0;
		foreach (nibs[n]) foreach (cols[c]) foreach (sels[s]) foreach (ids[i]) begin
			blk = {nibs[n], cols[c], sels[s]};
			rows.push_back('{blk, ids[i], expect_argb(blk, ids[i]), !(blk[127] || blk[127:125] == 3'h2)});
		end
		repeat (3) @(posedge clk_sys_i);
		sys_rst_i <= 1'h0;
		#1;
		chk32("argb reset", 32'h0, argb_o);
		chk1("valid reset", 1'h0, valid_o);
		// case table back to back, one answer per cycle.
		for (int j = 0; j <= rows.size(); j++) begin
			u_req.drive(j < rows.size(), (j < rows.size()) ? rows[j].blk : 128'h0, (j < rows.size()) ? rows[j].idx : 5'h0);
			#1;
			if (j > 0) begin
				chk1("valid", 1'h1, valid_o);
				chk1("unsupported", rows[j - 1].unsup, unsupported_o);
				chk32("argb", rows[j - 1].argb, argb_o);
			end else begin
				chk1("valid release", 1'h0, valid_o);
				chk1("unsupported release", 1'h0, unsupported_o);
			end
		end
		u_req.drive(1'h0, 128'h0, 5'h0);
		#1;
		chk1("valid idle", 1'h0, valid_o);
		chk32("argb idle", rows[rows.size() - 1].argb, argb_o);
		// reset wins over a pending request.
		u_req.drive(1'h1, rows[40].blk, rows[40].idx);
		sys_rst_i <= 1'h1;
		u_req.drive(1'h0, 128'h0, 5'h0);
		#1;
		chk1("valid mid reset", 1'h0, valid_o);
		chk32("argb mid reset", 32'h0, argb_o);
		@(posedge clk_sys_i);
		sys_rst_i <= 1'h0;
		u_req.drive(1'h1, rows[40].blk, rows[40].idx);
		u_req.drive(1'h0, 128'h0, 5'h0);
		#1;
		chk32("argb after reset", rows[40].argb, argb_o);
		test_done;
	end
endmodule
